// ---- dv/rocd_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rocd_master_model (
  input  wire logic         core_clk_in,
  input  wire logic [2:0]   resp_in,
  output logic              link_cycle_out,
  output logic      [255:0] image_out,
  output logic      [255:0] words_out
);
  initial begin
    link_cycle_out = 1'b0;
    image_out      = '0;
    words_out      = '0;
  end

  // These tasks move the image together with a scan, as a cyclic link does; request moves it without one
  task automatic link_bit(input int k, input int b, input logic v);
    @(posedge core_clk_in);
    image_out[16*k+b] <= v;
    link_cycle_out    <= 1'b1;
    @(posedge core_clk_in);
    link_cycle_out    <= 1'b0;
  endtask

  task automatic link_word(input int k, input logic [15:0] v);
    @(posedge core_clk_in);
    image_out[16*k+:16] <= v;
    link_cycle_out      <= 1'b1;
    @(posedge core_clk_in);
    link_cycle_out      <= 1'b0;
  endtask

  task automatic set_word(input int k, input logic [15:0] v);
    @(posedge core_clk_in);
    words_out[16*k+:16] <= v;
  endtask

  // Request held until its response is seen; ok also needs the response
  // to fall again once the request is gone
  task automatic request(input int b, input int r, input logic rw,
                         output logic ok);
    ok = 1'b0;
    @(posedge core_clk_in);
    image_out[b] <= 1'b1;
    image_out[3] <= rw;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge core_clk_in);
      ok = (resp_in[r] === 1'b1);
    end
    image_out[b] <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    ok = ok && (resp_in[r] === 1'b0);
  endtask
endmodule // rocd_master_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic          clk;
  logic          rst_n;
  logic          wb_req;
  logic          wb_we;
  logic [7:0]    wb_adr;
  logic [31:0]   wb_wdat;
  logic [31:0]   wb_rdat;
  logic          wb_ack;
  logic          link_cyc;
  logic [255:0]  image;
  logic [255:0]  words;
  logic          seq_run;
  logic [2:0]    resp;
  logic          rw_resp;
  logic [31:0]   rd_words;
  logic [3:0]    pulses;
  logic [1:0]    peak_mode;
  logic          chk;
  logic          hold;
  logic          track;
  logic [7:0]    cal;
  logic          err;
  logic [7:0]    err_code;
  logic [7:0]    err_aux;
  int            pcnt [4];
  int            err_count;
  int            check_count;
  logic [31:0]   rd;
  logic          ok;

  rocd_top rocd_top_i (
    .core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(wb_req),
    .wb_stb_in(wb_req), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(4'hF), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .link_cycle_in(link_cyc),
    .master_output_bit_in(image), .write_word_area_in(words),
    .seq_running_in(seq_run), .set_wr_resp_out(resp[0]),
    .gen_cmd_resp_out(resp[1]), .rw_resp_out(rw_resp),
    .mode_resp_out(resp[2]), .read_word_area_out(rd_words),
    .zero_pulse_out(pulses[0]), .zero_clear_pulse_out(pulses[1]),
    .peak_reset_pulse_out(pulses[2]), .multi_end_pulse_out(pulses[3]),
    .peak_mode_out(peak_mode), .check_display_out(chk),
    .hold_out(hold), .track_display_out(track), .cal_number_out(cal),
    .err_flag_out(err), .err_code_out(err_code), .err_aux_out(err_aux));

  rocd_master_model rocd_master_model_i (
    .core_clk_in(clk), .resp_in(resp), .link_cycle_out(link_cyc),
    .image_out(image), .words_out(words));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) if (pulses[i] === 1'b1) pcnt[i]++;
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; waits on ack, never on a fixed latency
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk);
    wb_req  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    data = wb_rdat;
    wb_req <= 1'b0;
    @(posedge clk);
    if (n >= 20) err_count++;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0, rd);
    check("cfg", 32'h0000_0012, rd);
    wb(1'b1, 8'h04, 32'hFFFF_FFFF, rd);
    wb(1'b0, 8'h04, 32'h0, rd);
    check("status", 32'h0, rd);
    wb(1'b0, 8'h0C, 32'h0, rd);
    check("unmapped", 32'h0, rd);
  endtask

  task automatic t_cmds();
    for (int k = 0; k < 12; k++) rocd_master_model_i.set_word(k, 16'h0F00);
    rocd_master_model_i.request(0, 0, 1'b0, ok);
    check("set handshake", 1, ok);
    rocd_master_model_i.set_word(12, 16'h1234);
    rocd_master_model_i.set_word(13, 16'hABCD);
    rocd_master_model_i.set_word(14, 16'h0003);
    rocd_master_model_i.request(2, 1, 1'b0, ok);
    check("gen write", 1, ok);
    rocd_master_model_i.set_word(12, 16'h5555);
    rocd_master_model_i.set_word(14, 16'h0005);
    rocd_master_model_i.request(2, 1, 1'b0, ok);
    rocd_master_model_i.set_word(14, 16'h0003);
    rocd_master_model_i.request(2, 1, 1'b1, ok);
    check("gen read", 1, ok);
    check("rw resp", 1, rw_resp);
    check("read words", 32'hABCD_1234, rd_words);
    rocd_master_model_i.request(4, 2, 1'b0, ok);
    check("mode handshake", 1, ok);
  endtask

  task automatic t_edges();
    int b [4] = '{0, 1, 3, 5};
    for (int i = 0; i < 4; i++) begin
      rocd_master_model_i.link_bit(1, b[i], 1'b1);
      rocd_master_model_i.link_bit(1, b[i], 1'b1);
      rocd_master_model_i.link_bit(1, b[i], 1'b0);
      settle();
      check("pulse count", 1, pcnt[i]);
    end
    for (int i = 1; i <= 4; i++) begin
      rocd_master_model_i.link_bit(1, 2, 1'b1);
      rocd_master_model_i.link_bit(1, 2, 1'b0);
      settle();
      check("peak mode", i % 4, peak_mode);
    end
  endtask

  task automatic t_levels();
    rocd_master_model_i.link_bit(1, 8, 1'b1);
    settle();
    check("check shown", 1, chk);
    rocd_master_model_i.link_bit(1, 9, 1'b1);
    settle();
    check("check hidden", 0, chk);
    rocd_master_model_i.link_word(1, 16'h0010);
    settle();
    wb(1'b0, 8'h04, 32'h0, rd);
    check("hold status", 1, rd[5]);
    rocd_master_model_i.link_word(1, 16'h8000);
    settle();
    check("hold released", 0, hold);
    wb(1'b1, 8'h00, 32'h0000_0011, rd);
    rocd_master_model_i.link_bit(1, 4, 1'b0);
    settle();
    check("track two", 1, track);
    rocd_master_model_i.link_word(1, 16'h0000);
    settle();
    check("peak two", 0, track);
    wb(1'b1, 8'h00, 32'h0000_0012, rd);
  endtask

  task automatic t_cal();
    rocd_master_model_i.link_word(2, 16'h0025);
    settle();
    check("cal locked", 0, cal);
    wb(1'b1, 8'h00, 32'h0000_0212, rd);
    rocd_master_model_i.link_word(2, 16'h0025);
    settle();
    check("cal bcd", 8'h25, cal);
    rocd_master_model_i.link_word(2, 16'h003A);
    settle();
    check("cal bad digit", 8'h25, cal);
    seq_run <= 1'b1;
    rocd_master_model_i.link_word(2, 16'h0031);
    settle();
    check("cal in seq", 8'h31, cal);
    check("err flag", 1, err);
    wb(1'b0, 8'h08, 32'h0, rd);
    check("err reg", 32'h0000_0263, rd);
    seq_run <= 1'b0;
    rocd_master_model_i.link_bit(7, 10, 1'b1);
    rocd_master_model_i.link_bit(7, 10, 1'b0);
    settle();
    check("err cleared", 0, {err, err_code, err_aux});
  endtask

  task automatic t_station();
    wb(1'b1, 8'h00, 32'h0000_0022, rd);
    rocd_master_model_i.link_bit(1, 0, 1'b1);
    rocd_master_model_i.link_bit(1, 0, 1'b0);
    settle();
    check("outside station", 1, pcnt[0]);
    rocd_master_model_i.link_bit(3, 0, 1'b1);
    rocd_master_model_i.link_bit(3, 0, 1'b0);
    settle();
    check("station base", 2, pcnt[0]);
  endtask

  task automatic t_one();
    wb(1'b1, 8'h00, 32'h0000_0210, rd);
    rocd_master_model_i.link_word(0, 16'h0000);
    seq_run <= 1'b1;
    rocd_master_model_i.link_word(0, 16'h0180);
    seq_run <= 1'b0;
    settle();
    check("one cal", 1, cal);
    check("one track", 1, track);
    check("one err", 1, err);
    rocd_master_model_i.link_bit(1, 9, 1'b1);
    rocd_master_model_i.link_bit(1, 10, 1'b1);
    settle();
    check("no remote clear", 1, err);
    check("init ignored", 1, cal);
    rocd_master_model_i.link_bit(0, 5, 1'b1);
    settle();
    check("one check shown", 1, chk);
    do_reset();
    settle();
    check("reset clears err", 0, {err, err_code});
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    wb_req  = 1'b0;
    wb_we   = 1'b0;
    wb_adr  = 8'h00;
    wb_wdat = 32'h0;
    seq_run = 1'b0;
    do_reset();
    t_regs();
    t_cmds();
    t_edges();
    t_levels();
    t_cal();
    t_station();
    t_one();
    report_and_stop();
  end

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

// ---- hdl/rocd_param_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module rocd_param_mem (
  input  wire logic        core_clk_in,
  input  wire logic        we_in,
  input  wire logic [4:0]  waddr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [4:0]  raddr_in,
  output logic      [15:0] rdata_out
);

  logic [15:0] mem_r [0:31];

  // Contents are undefined until written; no reset keeps this a plain RAM
  always_ff @(posedge core_clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_r[raddr_in];
  end

endmodule // rocd_param_mem
`default_nettype wire

// ---- hdl/rocd_pkg.sv ----
package rocd_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] REG_CFG_ADDR    = 8'h00;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h04;
  localparam logic [7:0] REG_ERROR_ADDR  = 8'h08;

  // Control register fields
  localparam int CFG_LAYOUT_LSB  = 0;
  localparam int CFG_STATION_LSB = 4;
  localparam int CFG_FSEL_LSB    = 8;
  localparam logic [15:0] CFG_RESET_VALUE = 16'h0012;

  // Station layouts
  localparam logic [1:0] LAYOUT_ONE  = 2'h0;
  localparam logic [1:0] LAYOUT_TWO  = 2'h1;
  localparam logic [1:0] LAYOUT_FOUR = 2'h2;

  // Link image: sixteen 16-bit words, two words per station
  localparam int IMG_WORDS        = 16;
  localparam int WORDS_PER_STN    = 2;

  // Multi-station bit positions
  localparam int BIT_SET_REQ   = 0;
  localparam int BIT_GEN_REQ   = 2;
  localparam int BIT_RW_SEL    = 3;
  localparam int BIT_MODE_REQ  = 4;
  localparam int BIT_ZERO      = 0;
  localparam int BIT_ZCLR      = 1;
  localparam int BIT_PEAK      = 2;
  localparam int BIT_PRESET    = 3;
  localparam int BIT_HOLD      = 4;
  localparam int BIT_MEND      = 5;
  localparam int BIT_CHK_ON    = 8;
  localparam int BIT_CHK_OFF   = 9;
  localparam int BIT_TRACK     = 15;
  localparam int BIT_INIT      = 9;
  localparam int BIT_ERR_CLR   = 10;
  // Single-station bit positions
  localparam int S1_CHK_ON     = 5;
  localparam int S1_CHK_OFF    = 6;
  localparam int S1_TRACK      = 7;
  localparam int S1_CAL_LSB    = 8;
  localparam int S1_INIT       = 9;

  // Write word area layout
  localparam logic [3:0] WW_GEN_DATA  = 4'hC;
  localparam logic [3:0] WW_CMD_NO    = 4'hE;
  localparam logic [3:0] SET_LAST_IDX = 4'hB;

  // Peak selection and error codes
  localparam logic [1:0] PEAK_MODE_LAST = 2'h3;
  localparam logic [1:0] FSEL_LINK_CAL  = 2'h2;
  localparam logic [7:0] ERR_CAL_CODE   = 8'h63;
  localparam logic [7:0] ERR_CAL_AUX    = 8'h02;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SET  = 5'b00010,
    ST_GWR  = 5'b00100,
    ST_GRD  = 5'b01000,
    ST_MODE = 5'b10000
  } rocd_state_t;

endpackage

// ---- hdl/rocd_rise_det.sv ----
`timescale 1ns/1ps
`default_nettype none
module rocd_rise_det #(
  parameter int W = 8
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         sample_in,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out
);

  logic [W-1:0] prev_r;

  // Previous value only moves on link cycles, so a held level never repeats
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r   <= '0;
      rise_out <= '0;
    end else begin
      rise_out <= sample_in ? (level_in & ~prev_r) : '0;
      if (sample_in) begin
        prev_r <= level_in;
      end
    end
  end

endmodule // rocd_rise_det
`default_nettype wire

// ---- hdl/rocd_top.sv ----
// Overview of operation
// - One-station layout has no error clear; only device reset clears errors.
// - Setting-write request stores the twelve setting words into memory.
// - General write stores two data words at the numbered parameter.
// - General read returns the numbered parameter in two read words.
// - Mode-switch request is answered but the mode word is not applied.
// - Zero, zero clear and peak reset act once per rising edge.
// - Each rising edge of peak command steps the peak/track selection.
// - Rising edge of forced-multi-end ends a multihold once.
// - Check-show edge shows check value; check-hide edge removes it.
// - Calibration number bits are read as a BCD value.
// - Calibration changes are taken only while function setting equals two.
// - Calibration change during a sequence raises error 99, auxiliary 2.
// - Initial-data request is accepted and ignored.
// - One-station layout puts initial-data request at second word bit 9.
// - Error-clear rising edge after an error zeroes type and number.
// - In one/two-station layout display bit high selects track, low peak.
// - One-station layout puts display select at first word bit 7.
// - Remote bit base index follows the configured station number.
`timescale 1ns/1ps
`default_nettype none
module rocd_top (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         wb_cyc_in,
  input  wire logic         wb_stb_in,
  input  wire logic         wb_we_in,
  input  wire logic [7:0]   wb_adr_in,
  input  wire logic [3:0]   wb_sel_in,
  input  wire logic [31:0]  wb_dat_in,
  output logic      [31:0]  wb_dat_out,
  output logic              wb_ack_out,
  input  wire logic         link_cycle_in,
  input  wire logic [255:0] master_output_bit_in,
  input  wire logic [255:0] write_word_area_in,
  input  wire logic         seq_running_in,
  output logic              set_wr_resp_out,
  output logic              gen_cmd_resp_out,
  output logic              rw_resp_out,
  output logic              mode_resp_out,
  output logic      [31:0]  read_word_area_out,
  output logic              zero_pulse_out,
  output logic              zero_clear_pulse_out,
  output logic              peak_reset_pulse_out,
  output logic              multi_end_pulse_out,
  output logic      [1:0]   peak_mode_out,
  output logic              check_display_out,
  output logic              hold_out,
  output logic              track_display_out,
  output logic      [7:0]   cal_number_out,
  output logic              err_flag_out,
  output logic      [7:0]   err_code_out,
  output logic      [7:0]   err_aux_out
);

  // Control register
  logic [15:0] cfg_r;
  wire  [1:0]  layout   = cfg_r[rocd_pkg::CFG_LAYOUT_LSB +: 2];
  wire  [3:0]  station  = cfg_r[rocd_pkg::CFG_STATION_LSB +: 4];
  wire  [1:0]  fsel     = cfg_r[rocd_pkg::CFG_FSEL_LSB +: 2];
  wire         single   = (layout == rocd_pkg::LAYOUT_ONE);
  wire         four     = (layout == rocd_pkg::LAYOUT_FOUR);

  // Station window into the link image
  wire  [4:0]  base_w = 5'((station - 4'h1) *
                           rocd_pkg::WORDS_PER_STN);

  // Image passed as an argument so the words follow every change of it
  function automatic logic [15:0] stn_word(input logic [255:0] img,
                                           input logic [4:0]   base,
                                           input logic [4:0]   ofs);
    logic [4:0] idx;
    idx = base + ofs;
    stn_word = (idx < 5'(rocd_pkg::IMG_WORDS)) ? img[{idx[3:0], 4'h0} +: 16]
                                               : 16'h0000;
  endfunction

  wire [15:0] w0  = stn_word(master_output_bit_in, base_w, 5'h00);
  wire [15:0] w1  = stn_word(master_output_bit_in, base_w, 5'h01);
  wire [15:0] w2  = stn_word(master_output_bit_in, base_w, 5'h02);
  wire [15:0] wsy = stn_word(master_output_bit_in, base_w,
                             four ? 5'h07 : 5'h03);

  // Command bit decode by layout
  wire set_req  = !single && w0[rocd_pkg::BIT_SET_REQ];
  wire gen_req  = !single && w0[rocd_pkg::BIT_GEN_REQ];
  wire rw_sel   = w0[rocd_pkg::BIT_RW_SEL];
  wire mode_req = !single && w0[rocd_pkg::BIT_MODE_REQ];
  wire [15:0] wb_basic = single ? w0 : w1;
  wire chk_on   = single ? w0[rocd_pkg::S1_CHK_ON]  : w1[rocd_pkg::BIT_CHK_ON];
  wire chk_off  = single ? w0[rocd_pkg::S1_CHK_OFF] : w1[rocd_pkg::BIT_CHK_OFF];
  wire mend     = !single && w1[rocd_pkg::BIT_MEND];
  wire track    = single ? w0[rocd_pkg::S1_TRACK]
                         : w1[rocd_pkg::BIT_TRACK];
  // No error clear exists in the one-station layout
  wire err_clr  = single ? 1'b0
                         : wsy[rocd_pkg::BIT_ERR_CLR];
  // Initial-data request (one-station word 1 bit 9, else system word bit 9)
  // is deliberately left undecoded: nothing is initialised.
  wire [7:0] cal_in = single ? {6'h00, w0[rocd_pkg::S1_CAL_LSB +: 2]}
                             : w2[7:0];

  // Edge detection on link cycles
  wire [7:0] cmd_lvl = {err_clr, chk_off, chk_on, mend,
                        wb_basic[rocd_pkg::BIT_PRESET],
                        wb_basic[rocd_pkg::BIT_PEAK],
                        wb_basic[rocd_pkg::BIT_ZCLR],
                        wb_basic[rocd_pkg::BIT_ZERO]};
  logic [7:0] rise;
  rocd_rise_det #(.W(8)) u_rise (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sample_in   (link_cycle_in),
    .level_in    (cmd_lvl),
    .rise_out    (rise)
  );

  // Calibration acceptance
  wire cal_bcd_ok = (cal_in[3:0] <= 4'h9) && (cal_in[7:4] <= 4'h9);
  wire cal_take   = link_cycle_in && (fsel == rocd_pkg::FSEL_LINK_CAL)
                    && cal_bcd_ok && (cal_in != cal_number_out);
  wire err_set    = cal_take && seq_running_in;
  wire err_clr_ok = rise[7] && err_flag_out;

  // Handshake engine
  rocd_pkg::rocd_state_t st_r;
  logic [3:0]  cnt_r;
  logic [15:0] mem_rd;
  wire  [15:0] cmd_no  = write_word_area_in[{rocd_pkg::WW_CMD_NO, 4'h0} +: 16];
  wire  [3:0]  ww_idx  = (st_r == rocd_pkg::ST_SET) ? cnt_r
                         : rocd_pkg::WW_GEN_DATA + {3'h0, cnt_r[0]};
  wire         mem_we  = (st_r == rocd_pkg::ST_SET) || (st_r == rocd_pkg::ST_GWR);
  wire  [4:0]  par_adr = {1'b1, cmd_no[2:0], cnt_r[0]};
  wire  [4:0]  mem_wa  = (st_r == rocd_pkg::ST_SET) ? {1'b0, cnt_r} : par_adr;
  wire  [15:0] mem_wd  = write_word_area_in[{ww_idx, 4'h0} +: 16];

  rocd_param_mem u_mem (
    .core_clk_in (core_clk_in),
    .we_in       (mem_we),
    .waddr_in    (mem_wa),
    .wdata_in    (mem_wd),
    .raddr_in    (par_adr),
    .rdata_out   (mem_rd)
  );

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r               <= rocd_pkg::ST_IDLE;
      cnt_r              <= 4'h0;
      set_wr_resp_out    <= 1'b0;
      gen_cmd_resp_out   <= 1'b0;
      rw_resp_out        <= 1'b0;
      mode_resp_out      <= 1'b0;
      read_word_area_out <= 32'h0000_0000;
    end else begin
      // Set, general and mode responses last until their requests fall; rw_resp_out keeps its value
      if (!set_req) set_wr_resp_out <= 1'b0;
      if (!gen_req) gen_cmd_resp_out <= 1'b0;
      if (!mode_req) mode_resp_out <= 1'b0;
      unique case (st_r)
        rocd_pkg::ST_IDLE: begin
          cnt_r <= 4'h0;
          if (set_req && !set_wr_resp_out) begin
            st_r <= rocd_pkg::ST_SET;
          end else if (gen_req && !gen_cmd_resp_out) begin
            st_r <= rw_sel ? rocd_pkg::ST_GRD : rocd_pkg::ST_GWR;
          end else if (mode_req && !mode_resp_out) begin
            st_r <= rocd_pkg::ST_MODE;
          end
        end
        rocd_pkg::ST_SET: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == rocd_pkg::SET_LAST_IDX) begin
            set_wr_resp_out <= 1'b1;
            st_r            <= rocd_pkg::ST_IDLE;
          end
        end
        rocd_pkg::ST_GWR: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r[0]) begin
            gen_cmd_resp_out <= 1'b1;
            rw_resp_out      <= 1'b0;
            st_r             <= rocd_pkg::ST_IDLE;
          end
        end
        rocd_pkg::ST_GRD: begin
          // Read data lag the address by one cycle
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h1) read_word_area_out[15:0] <= mem_rd;
          if (cnt_r == 4'h2) begin
            read_word_area_out[31:16] <= mem_rd;
            gen_cmd_resp_out          <= 1'b1;
            rw_resp_out               <= 1'b1;
            st_r                      <= rocd_pkg::ST_IDLE;
          end
        end
        rocd_pkg::ST_MODE: begin
          // Reserved: acknowledged, the mode word is never applied
          mode_resp_out <= 1'b1;
          st_r          <= rocd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Operator commands
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zero_pulse_out       <= 1'b0;
      zero_clear_pulse_out <= 1'b0;
      peak_reset_pulse_out <= 1'b0;
      multi_end_pulse_out  <= 1'b0;
      peak_mode_out        <= 2'h0;
      check_display_out    <= 1'b0;
      hold_out             <= 1'b0;
      track_display_out    <= 1'b0;
      cal_number_out       <= 8'h00;
    end else begin
      zero_pulse_out       <= rise[0];
      zero_clear_pulse_out <= rise[1];
      peak_reset_pulse_out <= rise[3];
      multi_end_pulse_out  <= rise[4];
      if (rise[2]) begin
        peak_mode_out <= (peak_mode_out == rocd_pkg::PEAK_MODE_LAST)
                         ? 2'h0 : peak_mode_out + 2'h1;
      end
      // Show wins when both edges land in one link cycle
      if (rise[5]) check_display_out <= 1'b1;
      else if (rise[6]) check_display_out <= 1'b0;
      if (link_cycle_in) begin
        hold_out          <= wb_basic[rocd_pkg::BIT_HOLD];
        track_display_out <= !four && track;
      end
      if (cal_take) cal_number_out <= cal_in;
    end
  end

  // Error store: a new error beats a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_flag_out <= 1'b0;
      err_code_out <= 8'h00;
      err_aux_out  <= 8'h00;
    end else if (err_set) begin
      err_flag_out <= 1'b1;
      err_code_out <= rocd_pkg::ERR_CAL_CODE;
      err_aux_out  <= rocd_pkg::ERR_CAL_AUX;
    end else if (err_clr_ok) begin
      err_flag_out <= 1'b0;
      err_code_out <= 8'h00;
      err_aux_out  <= 8'h00;
    end
  end

  // Bus slave: one wait state, unmapped reads return zero
  wire wb_req    = wb_cyc_in && wb_stb_in;
  wire sel_cfg   = (wb_adr_in == rocd_pkg::REG_CFG_ADDR);
  wire sel_stat  = (wb_adr_in == rocd_pkg::REG_STATUS_ADDR);
  wire sel_err   = (wb_adr_in == rocd_pkg::REG_ERROR_ADDR);
  wire [31:0] stat_w = {16'h0000, cal_number_out, 1'b0, track_display_out,
                        hold_out, check_display_out, 1'b0, peak_mode_out,
                        err_flag_out};
  wire [31:0] rd_mux = sel_cfg  ? {16'h0000, cfg_r}
                     : sel_stat ? stat_w
                     : sel_err  ? {16'h0000, err_aux_out, err_code_out}
                     : 32'h0000_0000;
  wire cfg_wr = wb_req && wb_ack_out && wb_we_in && sel_cfg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      cfg_r      <= rocd_pkg::CFG_RESET_VALUE;
    end else begin
      wb_ack_out <= wb_req && !wb_ack_out;
      if (wb_req && !wb_ack_out) wb_dat_out <= rd_mux;
      if (cfg_wr && wb_sel_in[0]) cfg_r[7:0]  <= wb_dat_in[7:0];
      if (cfg_wr && wb_sel_in[1]) cfg_r[15:8] <= wb_dat_in[15:8];
    end
  end

  // Checks
  sequence s_gen_rd;
    (st_r == rocd_pkg::ST_GRD) [*3] ##1 (gen_cmd_resp_out && rw_resp_out);
  endsequence

  property p_set_store;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(set_wr_resp_out) |-> $past(st_r == rocd_pkg::ST_SET) && !single;
  endproperty
  a_set_store: assert property (p_set_store)
    else $error("setting response without a store burst");

  property p_gen_read;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(st_r == rocd_pkg::ST_GRD) |-> s_gen_rd;
  endproperty
  a_gen_read: assert property (p_gen_read)
    else $error("general read did not answer in three cycles");

  property p_zero_once;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    zero_pulse_out |=> !zero_pulse_out;
  endproperty
  a_zero_once: assert property (p_zero_once)
    else $error("zero pulse longer than one cycle");

  property p_peak_step;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rise[2] |=> peak_mode_out != $past(peak_mode_out);
  endproperty
  a_peak_step: assert property (p_peak_step)
    else $error("peak selection did not advance");

  property p_check_on;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rise[5] |=> check_display_out;
  endproperty
  a_check_on: assert property (p_check_on)
    else $error("check display not shown");

  property p_hold_level;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    link_cycle_in |=> hold_out == $past(wb_basic[rocd_pkg::BIT_HOLD]);
  endproperty
  a_hold_level: assert property (p_hold_level)
    else $error("hold does not follow its level");

  property p_cal_gate;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (fsel != rocd_pkg::FSEL_LINK_CAL) |=> $stable(cal_number_out);
  endproperty
  a_cal_gate: assert property (p_cal_gate)
    else $error("calibration changed while not enabled");

  property p_cal_err;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cal_take && seq_running_in) |=> err_flag_out && err_code_out == 8'h63
      && err_aux_out == 8'h02;
  endproperty
  a_cal_err: assert property (p_cal_err)
    else $error("calibration error code wrong");

  property p_err_clear;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (err_clr_ok && !err_set) |=> !err_flag_out && err_code_out == 8'h00
      && err_aux_out == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error not cleared");

endmodule // rocd_top
`default_nettype wire
